/* rtl/eis_pkg.sv */
package eis_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50; // 20 MHz core clock
	localparam int unsigned WRITE_TIME_US_DEF = 1000; // Internal write time
	// ----------------------------------------
	// Select byte and memory layout
	// ----------------------------------------
	localparam int ADDR_W = 15; // 32K byte array
	localparam int PAGE_BITS = 6; // 64-byte page
	localparam logic [3:0] TYPE_ID_DEF = 4'h5; // Arbitrary type code
	localparam logic [3:0] LAST_DATA_BIT = 4'h7; // Count at 8th rise
	localparam logic [3:0] ACK_SLOT = 4'h8; // Count at 9th rise
	localparam logic [3:0] STOP_SLOT = 4'h1; // Count after the rise of the 10th slot
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
	localparam logic [5:0] PIN_SYNC_RST = 6'h03; // SCL and SDA idle high
	localparam logic [3:0] BIT_CNT_RST = 4'h0;
	// ----------------------------------------
	// Transfer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_SELECT,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA
	} eis_state_t;
endpackage

/* rtl/eis_link_if.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Bytes shifted in on the serial clock
// ----------------------------------------
interface eis_link_if;
	logic [7:0] rx_byte; // Last eight bits sampled on SCL rise
	modport link (output rx_byte);
	modport core (input rx_byte);
endinterface

/* rtl/eis_link_rx.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Receive shifter in the serial clock domain
// ----------------------------------------
module eis_link_rx
	import eis_pkg::*;
(
	input wire logic scl, // Serial clock from master
	input wire logic sda_in, // Raw data pin level
	eis_link_if.link lk // Shifted bits to the core
);
	// Shift on every rising SCL edge; no reset is needed because the
	// core reads this only after eight fresh rises since a Start, and
	// the value then holds for a whole bit period before it moves.
	always_ff @(posedge scl) begin
		lk.rx_byte <= {lk.rx_byte[6:0], sda_in};
	end
endmodule // eis_link_rx

/* rtl/eis_wr_timer.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Internal nonvolatile write cycle timer
// ----------------------------------------
module eis_wr_timer
	import eis_pkg::*;
#(
	parameter int unsigned CYCLES = 20000 // Write cycle length in clocks
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic start, // One-cycle trigger
	output logic busy // High while the cycle runs
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] count; // Elapsed clocks
	wire done = (count == LAST); // Final clock of the cycle

	// Run for exactly CYCLES clocks after the trigger
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			count <= '0;
		end else if (start && !busy) begin
			busy <= 1'b1;
			count <= '0;
		end else if (busy) begin
			busy <= !done;
			count <= count + CW'(1);
		end
	end
endmodule // eis_wr_timer

/* rtl/eis_slave.sv */
`timescale 1ns/1ns
module eis_slave
	import eis_pkg::*;
#(
	parameter int unsigned INTERNAL_WRITE_TIME_US = WRITE_TIME_US_DEF, // Write time
	parameter logic [3:0] DEV_TYPE_ID = TYPE_ID_DEF // Arbitrary type code
) (
	input wire logic clk, // 20 MHz core clock
	input wire logic rst_n, // Power-on reset, active low
	input wire logic scl, // Serial clock pin
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Data pin drive value, always low
	output logic sda_oe, // Pull the data pin low
	input wire logic chip_addr_pin_2, // Chip address strap, bit 2
	input wire logic chip_addr_pin_1, // Chip address strap, bit 1
	input wire logic chip_addr_pin_0, // Chip address strap, bit 0
	input wire logic write_protect_in, // High blocks array writes
	input wire logic [7:0] rd_data, // Array byte at mem_addr
	output logic [ADDR_W-1:0] mem_addr, // Array byte address
	output logic [7:0] mem_wdata, // Byte for the page latch
	output logic mem_wr, // Pulse: latch mem_wdata at mem_addr
	output logic write_start, // Pulse: internal write cycle begins
	output logic write_busy, // Internal write cycle running
	output logic standby // Idle and ready for a Start
);
	// ----------------------------------------
	// Derived timing
	// ----------------------------------------
	localparam int unsigned WR_CYCLES_RAW = INTERNAL_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned WR_CYCLES = (WR_CYCLES_RAW < 1) ? 1 : WR_CYCLES_RAW;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [5:0] pin_meta; // First stage, read by pin_sync only
	logic [5:0] pin_sync; // Second stage, safe to use
	logic scl_prev; // Last synced SCL for edges
	logic sda_prev; // Last synced SDA for edges
	wire [5:0] pin_raw = {chip_addr_pin_2, chip_addr_pin_1, chip_addr_pin_0,
		write_protect_in, sda_in, scl};
	wire scl_s = pin_sync[0]; // Synced serial clock
	wire sda_s = pin_sync[1]; // Synced serial data
	wire wp_s = pin_sync[2]; // Synced write protect
	wire [2:0] chip_s = pin_sync[5:3]; // Synced chip address straps

	// Two flops on every pin; the link clock edge is not usable here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_meta <= PIN_SYNC_RST;
			pin_sync <= PIN_SYNC_RST;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// Keep last synced levels for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl_s;
			sda_prev <= sda_s;
		end
	end

	// ----------------------------------------
	// Bus conditions
	// ----------------------------------------
	wire scl_high = scl_s && scl_prev; // SCL steady high
	wire start_ev = scl_high && sda_prev && !sda_s;
	wire stop_ev = scl_high && !sda_prev && sda_s;
	wire rise_ev = scl_s && !scl_prev; // SCL rose
	wire fall_ev = !scl_s && scl_prev; // SCL fell

	// ----------------------------------------
	// Link side receive shifter
	// ----------------------------------------
	eis_link_if lk ();

	// Bits are caught on the real SCL edge; the core reads the byte
	// after the synced rise, well before the next edge can shift it
	eis_link_rx u_link (
		.scl(scl),
		.sda_in(sda_in),
		.lk(lk.link)
	);

	wire [7:0] byte_in = lk.rx_byte; // Byte completed at 8th rise
	wire rx_ack_bit = lk.rx_byte[0]; // Level at the ninth rise

	// ----------------------------------------
	// Select byte decode
	// ----------------------------------------
	wire type_ok = (byte_in[7:4] == DEV_TYPE_ID);
	wire chip_ok = (byte_in[3:1] == chip_s);
	wire sel_match = type_ok && chip_ok;
	wire sel_read = byte_in[0];

	// ----------------------------------------
	// Transfer state
	// ----------------------------------------
	eis_state_t state; // Current transfer phase
	eis_state_t next_state;
	logic [3:0] bit_cnt; // SCL rises in the byte
	logic [3:0] next_bit_cnt;
	logic [7:0] tx_shift; // Read byte going out
	logic [7:0] next_tx;
	logic ack_pend; // Drive ack at the next fall
	logic next_ack_pend;
	logic [ADDR_W-1:0] addr; // Internal address counter
	logic [ADDR_W-1:0] next_addr;
	logic next_oe; // Next data pin pull
	logic wr_pending; // Data bytes await a write cycle
	logic next_wr_pending;
	logic next_mem_wr; // Next latch strobe
	logic [7:0] next_wdata; // Next latched data byte
	logic next_write_start; // Next write trigger

	// Stop right after a data byte ack: the tenth slot of a write. A Stop
	// always needs one SCL rise after the ack fall, so the count is one here
	wire commit_ok = (state == ST_WDATA) && wr_pending && (bit_cnt == STOP_SLOT);

	// Next-state decode
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_tx = tx_shift;
		next_ack_pend = ack_pend;
		next_addr = addr;
		next_oe = sda_oe;
		next_wr_pending = wr_pending;
		next_mem_wr = 1'b0;
		next_wdata = mem_wdata;
		next_write_start = 1'b0;
		if (write_busy) begin
			// Deaf and off the bus during the write cycle
			next_state = ST_STANDBY;
			next_oe = 1'b0;
			next_ack_pend = 1'b0;
			next_bit_cnt = BIT_CNT_RST;
		end else if (start_ev) begin
			// Any Start outside a write cycle, repeated or not, begins a select byte
			next_state = ST_SELECT;
			next_bit_cnt = BIT_CNT_RST;
			next_ack_pend = 1'b0;
			next_oe = 1'b0;
			next_wr_pending = 1'b0;
		end else if (stop_ev) begin
			// Stop always ends the transfer
			next_state = ST_STANDBY;
			next_bit_cnt = BIT_CNT_RST;
			next_ack_pend = 1'b0;
			next_oe = 1'b0;
			next_wr_pending = 1'b0;
			next_write_start = commit_ok;
		end else if (rise_ev && state != ST_STANDBY) begin
			if (bit_cnt == ACK_SLOT) begin
				// Ninth rise closes the byte
				next_bit_cnt = BIT_CNT_RST;
				if (state == ST_RDATA && rx_ack_bit) begin
					// Master did not ack the read byte
					next_state = ST_STANDBY;
					next_oe = 1'b0;
				end
			end else begin
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt == LAST_DATA_BIT) begin
					case (state)
						ST_SELECT: begin
							if (sel_match) begin
								next_ack_pend = 1'b1;
								next_state = sel_read ? ST_RDATA : ST_ADDR_HI;
							end else begin
								next_state = ST_STANDBY;
							end
						end
						ST_ADDR_HI: begin
							// Top address bit is a don't care
							next_addr = {byte_in[6:0], addr[7:0]};
							next_ack_pend = 1'b1;
							next_state = ST_ADDR_LO;
						end
						ST_ADDR_LO: begin
							next_addr = {addr[14:8], byte_in};
							next_ack_pend = 1'b1;
							next_state = ST_WDATA;
						end
						ST_WDATA: begin
							if (!wp_s) begin
								// Accept into the page latch, wrap inside the page
								next_ack_pend = 1'b1;
								next_mem_wr = 1'b1;
								next_wdata = byte_in;
								next_wr_pending = 1'b1;
								next_addr = {addr[ADDR_W-1:PAGE_BITS],
									addr[PAGE_BITS-1:0] + 6'h01};
							end
							// Protected data byte: no ack, nothing latched
						end
						default: begin
							next_state = state; // Read bytes counted only
						end
					endcase
				end
			end
		end else if (fall_ev && state != ST_STANDBY) begin
			if (ack_pend) begin
				next_oe = 1'b1;
				next_ack_pend = 1'b0;
			end else if (state == ST_RDATA) begin
				// Read path never looks at write protect
				if (bit_cnt == BIT_CNT_RST) begin
					next_tx = rd_data;
					next_oe = !rd_data[7];
					next_addr = addr + 15'h0001;
				end else if (bit_cnt == ACK_SLOT) begin
					next_oe = 1'b0;
				end else begin
					next_tx = {tx_shift[6:0], 1'b0};
					next_oe = !tx_shift[6];
				end
			end else begin
				next_oe = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	// Power-on reset leaves the block in standby, listening for a Start
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_STANDBY;
			bit_cnt <= BIT_CNT_RST;
			ack_pend <= 1'b0;
			wr_pending <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			ack_pend <= next_ack_pend;
			wr_pending <= next_wr_pending;
		end
	end

	// Address counter and outgoing byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr <= ADDR_RST;
			tx_shift <= 8'h00;
		end else begin
			addr <= next_addr;
			tx_shift <= next_tx;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Open drain: only ever pull low, never drive high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			sda_oe <= next_oe;
		end
	end

	// ----------------------------------------
	// Array side outputs
	// ----------------------------------------
	// mem_addr lags addr by one clock so it still shows the latched
	// byte's address in the cycle that mem_wr pulses
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_addr <= ADDR_RST;
			mem_wdata <= 8'h00;
			mem_wr <= 1'b0;
			write_start <= 1'b0;
			standby <= 1'b1;
		end else begin
			mem_addr <= addr;
			mem_wdata <= next_wdata;
			mem_wr <= next_mem_wr;
			write_start <= next_write_start;
			standby <= (state == ST_STANDBY) && !write_busy;
		end
	end

	// ----------------------------------------
	// Internal write cycle
	// ----------------------------------------
	// Timer starts on the same edge as write_start
	eis_wr_timer #(
		.CYCLES(WR_CYCLES)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(next_write_start),
		.busy(write_busy)
	);
endmodule // eis_slave

/* verif/eis_slave_props.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the slave front end
// ----------------------------------------
module eis_slave_props
	import eis_pkg::*;
#(
	parameter int unsigned INTERNAL_WRITE_TIME_US = 1 // Write time
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic scl, // Serial clock pin
	input wire logic sda_in, // Data pin level
	input wire logic sda_out, // Drive value
	input wire logic sda_oe, // Pull enable
	input wire logic chip_addr_pin_2, // Strap 2
	input wire logic chip_addr_pin_1, // Strap 1
	input wire logic chip_addr_pin_0, // Strap 0
	input wire logic write_protect_in, // Protect
	input wire logic [7:0] rd_data, // Array byte
	input wire logic [ADDR_W-1:0] mem_addr, // Array address
	input wire logic [7:0] mem_wdata, // Latch byte
	input wire logic mem_wr, // Latch pulse
	input wire logic write_start, // Cycle start
	input wire logic write_busy, // Cycle running
	input wire logic standby // Idle
);
	localparam int unsigned WR = INTERNAL_WRITE_TIME_US * 1000 / CLK_PERIOD_NS; // Busy clocks
	int unsigned busy_cnt; // Clocks of busy so far
	default clocking cb @(posedge clk); endclocking
	// ----------------------------------------
	// Busy length counter, too long to unroll
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n || !write_busy) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	// Launch is a pulse, then a held busy level
	sequence s_launch;
		##1 !write_start && write_busy [*8];
	endsequence
	rst_idle_a: assert property (disable iff (!rst_n) $rose(rst_n) |-> standby && !sda_oe)
		else $error("outputs not idle after reset");
	busy_quiet_a: assert property (disable iff (!rst_n) write_busy |-> !sda_oe)
		else $error("data pin driven during write cycle");
	busy_len_a: assert property (disable iff (!rst_n) $fell(write_busy) |-> busy_cnt == WR)
		else $error("write cycle length wrong");
	start_busy_a: assert property (disable iff (!rst_n) write_start |-> s_launch)
		else $error("write start not followed by busy");
	busy_standby_a: assert property (disable iff (!rst_n) write_busy |-> !standby)
		else $error("standby during write cycle");
	busy_done_a: assert property (disable iff (!rst_n) $fell(write_busy) |-> ##[0:2] standby)
		else $error("no standby after write cycle");
	wp_block_a: assert property (disable iff (!rst_n) write_protect_in [*6] |-> !mem_wr)
		else $error("array write while protected");
	wr_pulse_a: assert property (disable iff (!rst_n) mem_wr |=> !mem_wr)
		else $error("latch strobe longer than one clock");
	oe_edge_a: assert property (disable iff (!rst_n) $changed(sda_oe) |-> !scl)
		else $error("data drive changed with clock high");
	od_low_a: assert property (disable iff (!rst_n) sda_oe |-> !sda_out)
		else $error("data pin driven high");
endmodule // eis_slave_props

bind eis_slave eis_slave_props #(.INTERNAL_WRITE_TIME_US(INTERNAL_WRITE_TIME_US)) u_props (
	.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.chip_addr_pin_2(chip_addr_pin_2), .chip_addr_pin_1(chip_addr_pin_1),
	.chip_addr_pin_0(chip_addr_pin_0), .write_protect_in(write_protect_in),
	.rd_data(rd_data), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
	.write_start(write_start), .write_busy(write_busy), .standby(standby));

/* verif/eis_master_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Bus master, stepped by the link clock
// ----------------------------------------
module eis_master_model #(
	parameter int H = 20 // Link ticks per bit phase
) (
	input wire logic lclk, // Link base clock
	input wire logic sda, // Resolved data line
	output logic scl, // Serial clock, still between frames
	output logic sda_low // Pull data low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tk();
		repeat (H) @(posedge lclk);
	endtask
	// Data falls with clock high; also a repeated start
	task automatic start();
		tk();
		sda_low = 1'b0;
		tk();
		scl = 1'b1;
		tk();
		sda_low = 1'b1;
		tk();
		scl = 1'b0;
	endtask
	// Data rises with clock high
	task automatic stop();
		tk();
		sda_low = 1'b1;
		tk();
		scl = 1'b1;
		tk();
		sda_low = 1'b0;
		tk();
	endtask
	// Data moves only with clock low, well past the fall
	task automatic bit_x(input logic b, output logic s);
		tk();
		sda_low = ~b;
		tk();
		scl = 1'b1;
		tk();
		s = sda;
		scl = 1'b0;
	endtask
	// Byte out from the top bit, line released for the ack slot
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
		end
		bit_x(1'b1, s);
		ack = ~s;
	endtask
	// Byte in; an ack asks for the next one
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(~mack, s);
	endtask
endmodule // eis_master_model

/* verif/eis_slave_tb_top.sv */
`timescale 1ns/1ns
module eis_slave_tb_top
	import eis_pkg::*;
();
	localparam logic [3:0] TID = 4'h5; // Arbitrary type code
	localparam logic [2:0] STRAP = 3'h5; // Strapped chip address
	logic clk, lclk, rst_n, scl, sda_low, sda_in, sda_out, sda_oe, wp;
	logic mem_wr, write_start, write_busy, standby;
	logic [2:0] strap; // Chip address straps
	logic [7:0] rd_data, mem_wdata;
	logic [ADDR_W-1:0] mem_addr;
	logic [7:0] mem [0:32767]; // Array model
	logic [15:0] n_wr, n_ws; // Latch and cycle pulse counts
	int n_errors, n_tests;
	// Open-drain line with pull-up
	assign sda_in = ~sda_low & (sda_oe ? sda_out : 1'b1);
	assign rd_data = mem[mem_addr];
	eis_slave #(.INTERNAL_WRITE_TIME_US(20), .DEV_TYPE_ID(TID)) uut (
		.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_addr_pin_2(strap[2]), .chip_addr_pin_1(strap[1]),
		.chip_addr_pin_0(strap[0]), .write_protect_in(wp), .rd_data(rd_data),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
		.write_start(write_start), .write_busy(write_busy), .standby(standby));
	eis_master_model m (.lclk(lclk), .sda(sda_in), .scl(scl), .sda_low(sda_low));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Link clock, 15 ns, offset phase
	initial begin
		lclk = 1'b0;
		#4;
		forever begin
			#7 lclk = ~lclk;
			#8 lclk = ~lclk;
		end
	end
	// Array model and pulse counters; counters cleared by reset
	always @(posedge clk) begin
		if (!rst_n) begin
			n_wr <= 16'h0000;
			n_ws <= 16'h0000;
		end else begin
			if (mem_wr === 1'b1) begin
				mem[mem_addr] <= mem_wdata;
				n_wr <= n_wr + 16'h0001;
			end
			if (write_start === 1'b1) n_ws <= n_ws + 16'h0001;
		end
	end
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic sel(input logic [3:0] tid, input logic [2:0] ca, input logic rw, output logic ack);
		m.start();
		m.wr_byte({tid, ca, rw}, ack);
	endtask
	// Write select and both address bytes
	task automatic set_addr(input logic [15:0] a);
		logic k;
		sel(TID, STRAP, 1'b0, k);
		chk_bit(k, 1'b1);
		m.wr_byte(a[15:8], k);
		chk_bit(k, 1'b1);
		m.wr_byte(a[7:0], k);
		chk_bit(k, 1'b1);
	endtask
	task automatic wr_cmd(input logic [15:0] a, input int n, input logic [7:0] d0, input logic dack);
		logic k;
		set_addr(a);
		for (int i = 0; i < n; i++) begin
			m.wr_byte(d0 + i[7:0], k);
			chk_bit(k, dack);
		end
		m.stop();
	endtask
	task automatic rd1(input logic mack, input logic [7:0] exp);
		logic [7:0] d;
		m.rd_byte(mack, d);
		chk_val({8'h00, d}, {8'h00, exp});
	endtask
	task automatic conclude();
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog, run needs about 0.3 ms
	initial begin
		#3000000;
		n_errors++;
		conclude();
	end
	initial begin
		logic a;
		rst_n = 1'b0;
		wp = 1'b0;
		strap = STRAP;
		for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h5A;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk_bit(standby, 1'b1);
		chk_bit(sda_out, 1'b0);
		// Only the strapped chip address is answered
		for (int c = 0; c < 8; c++) begin
			sel(TID, c[2:0], 1'b0, a);
			chk_bit(a, c[2:0] == STRAP);
			repeat (8) @(negedge clk);
			chk_bit(sda_oe, 1'b0);
			m.stop();
			chk_bit(standby, 1'b1);
		end
		sel(4'h6, STRAP, 1'b0, a);
		chk_bit(a, 1'b0);
		m.stop();
		// Page write across the page end, then poll while busy
		wr_cmd(16'h007E, 3, 8'hA1, 1'b1);
		chk_val(n_ws, 16'h0001);
		sel(TID, STRAP, 1'b0, a);
		chk_bit(a, 1'b0);
		m.stop();
		for (int i = 0; i < 1000 && write_busy !== 1'b0; i++) @(negedge clk);
		// A cycle that outlives the limit counts as a mismatch here
		chk_bit(write_busy, 1'b0);
		repeat (4) @(negedge clk);
		chk_bit(standby, 1'b1);
		chk_val({8'h00, mem[15'h0040]}, 16'h00A3);
		// Protected write: no data ack, no cycle
		wp = 1'b1;
		wr_cmd(16'h0100, 2, 8'hB0, 1'b0);
		chk_val(n_wr, 16'h0003);
		chk_val(n_ws, 16'h0001);
		// Random then sequential read, still protected
		set_addr(16'h007E);
		sel(TID, STRAP, 1'b1, a);
		chk_bit(a, 1'b1);
		rd1(1'b1, 8'hA1);
		rd1(1'b1, 8'hA2);
		rd1(1'b0, 8'h80 ^ 8'h5A);
		m.stop();
		chk_bit(standby, 1'b1);
		@(negedge clk);
		wp = 1'b0;
		// Current address read carries on after the last byte
		sel(TID, STRAP, 1'b1, a);
		chk_bit(a, 1'b1);
		rd1(1'b0, 8'h81 ^ 8'h5A);
		m.stop();
		// Reset in mid transfer
		sel(TID, STRAP, 1'b0, a);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		chk_bit(sda_oe, 1'b0);
		chk_bit(standby, 1'b1);
		rst_n = 1'b1;
		m.stop();
		chk_bit(standby, 1'b1);
		conclude();
	end
endmodule // eis_slave_tb_top
